// ### core/liulb_regs.vh
// register offsets, field positions and timing counts for the loopback/status bank
// assumes a 5-bit register address per channel and an 8-bit data path
`ifndef LIULB_REGS_VH
`define LIULB_REGS_VH
`define LIULB_ADDR_LOOP_CTRL   5'h05
`define LIULB_ADDR_STATUS      5'h06
`define LIULB_ADDR_IMASK       5'h07
`define LIULB_ADDR_RINFO1      5'h08
`define LIULB_ADDR_RINFO2      5'h09
`define LIULB_ADDR_SUMMARY_LO  5'h16
`define LIULB_LOOP_CTRL_RESET  8'h00
`define LIULB_IMASK_RESET      8'h00
`define LIULB_BIT_LOCAL        7
`define LIULB_BIT_REMOTE       6
`define LIULB_BIT_AUTO         5
`define LIULB_BIT_ANALOG       4
`define LIULB_BIT_JBYP         3
`define LIULB_ST_LOOP_UP       7
`define LIULB_ST_LOOP_DN       6
`define LIULB_ST_TXCLK_LOSS    5
`define LIULB_ST_ALL_ONES      4
`define LIULB_ST_CARRIER_LOSS  3
`define LIULB_RI2_AUTO_LOOP    1
`define LIULB_CODE_TIME_S      5
`define LIULB_CLK_HZ           250000000
`endif

// ### core/liulb_status_bit.v
// one status bit with the mask-write / read-clear scheme and interrupt request
// assumes the parent decodes writes and reads of its register into per-bit strobes
`default_nettype none
module liulb_status_bit #(
    parameter LATCHED = 1,
    parameter HOLD_ON_READ = 0,
    parameter EDGE_BOTH = 0
) (
    input  wire CLK,
    input  wire RST,
    input  wire cond,
    input  wire upd,
    input  wire rd,
    output wire val,
    output wire irq
);
    reg lat_q;
    reg shown_q;
    reg cond_q;
    reg irq_q;
    wire changed = cond ^ cond_q;
    wire event_on = EDGE_BOTH ? changed : (cond & ~cond_q);
    // latched event capture; set beats a read clear
    always @(posedge CLK) begin
        if (RST) begin
            lat_q   <= 1'b0;
            shown_q <= 1'b0;
            cond_q  <= 1'b0;
            irq_q   <= 1'b0;
        end else begin
            cond_q <= cond;
            if (cond & (LATCHED == 1))
                lat_q <= 1'b1;
            else if (rd)
                lat_q <= HOLD_ON_READ ? cond : 1'b0;
            if (upd)
                shown_q <= (LATCHED == 1) ? (lat_q | cond) : cond;
            if (event_on)
                irq_q <= 1'b1;
            else if (rd)
                irq_q <= 1'b0;
        end
    end
    assign val = shown_q;
    assign irq = irq_q;
endmodule // liulb_status_bit
`default_nettype wire

// ### core/liulb_bank.v
// loopback control, status/info registers and interrupt logic for four channels
// assumes a simple synchronous host strobe port: address, write and read strobes
`default_nettype none
`include "liulb_regs.vh"
// register map, per channel, five-bit address
//   05 loopback control, read and write
//   06 event status, mask write then read
//   07 interrupt mask, read and write
//   08 receive info one, mask write then read
//   09 receive info two, mask write then read
//   16 to 1f channel interrupt summary
//   any other address reads as zero
// writes to unmapped places are dropped
// control bits, high to low
//   7 local loop
//   6 manual remote loop
//   5 auto remote loop enable
//   4 analog loop
//   3 receive jitter attenuator bypass
//   2 to 0 error count select
// event status bits, high to low
//   7 loop-up code seen, latched, rising edge
//   6 loop-down code seen, latched, rising edge
//   5 transmit clock loss, real time, both edges
//   4 unframed all ones, latched and held, both edges
//   3 carrier loss, latched and held, both edges
//   2 to 0 real time, rising edge
// info one bits are all latched
// info two bit 1 shows the auto loop state
// info two bits other than 1 are latched
// the condition input at info two bit 1 is unused
// each channel has its own copy of everything
// host side ports
//   CH_SEL, ADDR, WDATA, WR, RD in
//   RDATA out, registered
// line side ports
//   condition inputs, one byte per channel
//   loop-up and loop-down code levels
//   loop controls and error select out
//   INT_N out, active low
// everything runs on CLK
// RST is synchronous and active high
// inputs are taken as synchronous to CLK
// the host decodes nothing else on this port
module liulb_bank #(
    parameter NCH = 4,
    parameter CODE_CYCLES = `LIULB_CODE_TIME_S * `LIULB_CLK_HZ
) (
    input  wire          CLK,
    input  wire          RST,
    input  wire [1:0]    CH_SEL,
    input  wire [4:0]    ADDR,
    input  wire [7:0]    WDATA,
    input  wire          WR,
    input  wire          RD,
    output reg  [7:0]    RDATA,
    input  wire [8*NCH-1:0] STATUS_COND,
    input  wire [8*NCH-1:0] RINFO1_COND,
    input  wire [8*NCH-1:0] RINFO2_COND,
    input  wire [NCH-1:0] LOOP_UP_SEEN,
    input  wire [NCH-1:0] LOOP_DN_SEEN,
    output reg  [NCH-1:0] LOCAL_LOOP,
    output reg  [NCH-1:0] REMOTE_LOOP,
    output reg  [NCH-1:0] ANALOG_LOOP,
    output reg  [NCH-1:0] RX_JA_BYPASS,
    output reg  [3*NCH-1:0] ERR_CNT_SEL,
    output wire          INT_N
);
    localparam ST_IDLE = 3'b001;
    localparam ST_UP   = 3'b010;
    localparam ST_LOOP = 3'b100;
    localparam [31:0] CODE_MAX = CODE_CYCLES;
    wire [NCH-1:0] ch_irq;
    wire [7:0] st_v [0:NCH-1];
    wire [7:0] r1_v [0:NCH-1];
    wire [7:0] r2_v [0:NCH-1];
    reg  [7:0] ctrl_q [0:NCH-1];
    reg  [7:0] mask_q [0:NCH-1];
    genvar c, b;
    generate
        for (c = 0; c < NCH; c = c + 1) begin : g_ch
            localparam [1:0] CH_ID = c;
            wire sel = (CH_SEL == CH_ID);
            wire wr_st = sel & WR & (ADDR == `LIULB_ADDR_STATUS);
            wire wr_r1 = sel & WR & (ADDR == `LIULB_ADDR_RINFO1);
            wire wr_r2 = sel & WR & (ADDR == `LIULB_ADDR_RINFO2);
            wire rd_st = sel & RD & (ADDR == `LIULB_ADDR_STATUS);
            wire rd_r1 = sel & RD & (ADDR == `LIULB_ADDR_RINFO1);
            wire rd_r2 = sel & RD & (ADDR == `LIULB_ADDR_RINFO2);
            wire [7:0] st_irq;
            reg  [2:0] state_q;
            reg  [31:0] tmr_q;
            wire auto_loop = state_q[2];
            wire [7:0] r2_cond;
            // host port timing
            //   strobes are one clock wide, taken at the edge
            //   a write lands at that same edge
            //   read data is registered and shown next cycle
            //   read data holds until the next read strobe
            //   back to back strobes are fine
            // channel select picks the bank for each access
            // the summary ignores the channel select
            // so any channel may be used to fetch it
            // control and mask reset to zero
            // so all loops start off and all sources masked
            // mask bit zero blocks a source
            // mask bit one lets it reach the pin
            // the mask does not touch the status view
            // the control byte reads back as written
            // control and mask registers
            always @(posedge CLK) begin
                if (RST) begin
                    ctrl_q[c] <= `LIULB_LOOP_CTRL_RESET;
                    mask_q[c] <= `LIULB_IMASK_RESET;
                end else if (sel & WR) begin
                    if (ADDR == `LIULB_ADDR_LOOP_CTRL)
                        ctrl_q[c] <= WDATA;
                    if (ADDR == `LIULB_ADDR_IMASK)
                        mask_q[c] <= WDATA;
                end
            end
            // auto remote loop machine
            //   idle: waiting for a loop-up code
            //   up: loop-up code seen, timer running
            //   loop: remote loop on, watching for loop-down
            // the loop-up code must be seen without a break
            // a dropout while up sends the machine to idle
            // a dropout while looped restarts the down timer
            // the timer is 32 bits wide
            // wide enough for five seconds at the full clock
            // code time in cycles is a parameter
            // so a bench may shorten it
            // clearing the enable forces idle at once
            // and zeroes the timer
            // this covers the one-to-zero step of the enable
            // setting the enable again starts from idle
            // the detect inputs are levels from the
            // pattern detectors, assumed already filtered
            // the manual remote bit is not used here
            // the two sources meet at the remote loop output
            // states are one-hot, three bits
            // an illegal code falls back to idle
            // reaching the limit in up moves to loop
            // reaching the limit in loop moves to idle
            // the timer stops at zero while idle
            // automatic remote loop machine with code timer
            always @(posedge CLK) begin
                if (RST) begin
                    state_q   <= ST_IDLE;
                    tmr_q     <= 32'h0;
                end else begin
                    if (!ctrl_q[c][`LIULB_BIT_AUTO]) begin
                        state_q <= ST_IDLE;
                        tmr_q   <= 32'h0;
                    end else begin
                        case (state_q)
                            ST_IDLE: begin
                                tmr_q <= 32'h0;
                                if (LOOP_UP_SEEN[c])
                                    state_q <= ST_UP;
                            end
                            ST_UP: begin
                                if (!LOOP_UP_SEEN[c]) begin
                                    state_q <= ST_IDLE;
                                    tmr_q   <= 32'h0;
                                end else if (tmr_q >= CODE_MAX - 32'h1) begin
                                    state_q <= ST_LOOP;
                                    tmr_q   <= 32'h0;
                                end else
                                    tmr_q <= tmr_q + 32'h1;
                            end
                            ST_LOOP: begin
                                if (!LOOP_DN_SEEN[c])
                                    tmr_q <= 32'h0;
                                else if (tmr_q >= CODE_MAX - 32'h1) begin
                                    state_q <= ST_IDLE;
                                    tmr_q   <= 32'h0;
                                end else
                                    tmr_q <= tmr_q + 32'h1;
                            end
                            default: begin
                                state_q <= ST_IDLE;
                                tmr_q   <= 32'h0;
                            end
                        endcase
                    end
                end
            end
            // loop outputs are registered copies of control
            // they trail the control write by one edge
            // remote loop is manual bit or auto state
            // error count select passes the low three bits
            // the error counters themselves live elsewhere
            // jitter bypass only steers the receive clock
            // the backplane clock keeps the attenuator
            // local loop leaves the transmit side as it is
            // analog loop keeps the line drivers running
            // all outputs are zero in reset
            // so no loop is active before the host writes
            // loop controls out, registered
            always @(posedge CLK) begin
                if (RST) begin
                    LOCAL_LOOP[c]   <= 1'b0;
                    REMOTE_LOOP[c]  <= 1'b0;
                    ANALOG_LOOP[c]  <= 1'b0;
                    RX_JA_BYPASS[c] <= 1'b0;
                    ERR_CNT_SEL[3*c+2:3*c] <= 3'h0;
                end else begin
                    LOCAL_LOOP[c]   <= ctrl_q[c][`LIULB_BIT_LOCAL];
                    REMOTE_LOOP[c]  <= ctrl_q[c][`LIULB_BIT_REMOTE] | auto_loop;
                    ANALOG_LOOP[c]  <= ctrl_q[c][`LIULB_BIT_ANALOG];
                    RX_JA_BYPASS[c] <= ctrl_q[c][`LIULB_BIT_JBYP];
                    ERR_CNT_SEL[3*c+2:3*c] <= ctrl_q[c][2:0];
                end
            end
            // three status registers of eight bits
            // one small cell per bit, parameters set its kind
            // latched: set by the condition, cleared by a read
            // held: a read leaves it set while the alarm stays
            // real time: the view copies the live condition
            // the view only moves on a mask write
            // a one in the mask refreshes that bit
            // a zero in the mask keeps the old view
            // a read clears the latch, not the view
            // so the host writes back the masked result
            // that second write brings the cleared view out
            // an event arriving between read and write back
            // sets the latch again and shows on the next poll
            // interrupt flags exist only for event status
            // info registers never raise the interrupt
            // set beats clear when both land in one cycle
            // so no event is lost across a read
            // both-edge bits flag a change either way
            // other bits flag only a rising condition
            // cells share the clock and reset of the bank
            // the strobes come from the address decode above
            // a write to another channel leaves these alone
            assign r2_cond = {RINFO2_COND[8*c+7:8*c+2], auto_loop, RINFO2_COND[8*c]};
            for (b = 0; b < 8; b = b + 1) begin : g_bit
                liulb_status_bit #(
                    .LATCHED      ((b == 7 || b == 6 || b == 4 || b == 3) ? 1 : 0),
                    .HOLD_ON_READ ((b == 4 || b == 3) ? 1 : 0),
                    .EDGE_BOTH    ((b == 5 || b == 4 || b == 3) ? 1 : 0)
                ) u_st (
                    .CLK  (CLK),
                    .RST  (RST),
                    .cond (STATUS_COND[8*c+b]),
                    .upd  (wr_st & WDATA[b]),
                    .rd   (rd_st),
                    .val  (st_v[c][b]),
                    .irq  (st_irq[b])
                );
                liulb_status_bit #(
                    .LATCHED(1), .HOLD_ON_READ(0), .EDGE_BOTH(0)
                ) u_r1 (
                    .CLK  (CLK),
                    .RST  (RST),
                    .cond (RINFO1_COND[8*c+b]),
                    .upd  (wr_r1 & WDATA[b]),
                    .rd   (rd_r1),
                    .val  (r1_v[c][b]),
                    .irq  ()
                );
                liulb_status_bit #(
                    .LATCHED((b == 1) ? 0 : 1), .HOLD_ON_READ(0), .EDGE_BOTH(0)
                ) u_r2 (
                    .CLK  (CLK),
                    .RST  (RST),
                    .cond (r2_cond[b]),
                    .upd  (wr_r2 & WDATA[b]),
                    .rd   (rd_r2),
                    .val  (r2_v[c][b]),
                    .irq  ()
                );
            end
            // each flag is gated by its mask bit
            // a mask change acts on the next cycle
            // flags stay pending while masked
            // unmasking later pulls the pin low then
            // a status read clears every flag of the channel
            // a new event during that read keeps its flag
            // channels are independent
            // one pending channel holds the pin low
            // for all others
            // masked interrupt per channel
            assign ch_irq[c] = |(st_irq & mask_q[c]);
        end
    endgenerate
    // summary comes first, for every address from 16 up
    // one bit per channel, channel zero at bit zero
    // unused high summary bits read as zero
    // a status read clears latches in the cells
    // the byte returned is the view before that clear
    // unmapped low addresses read zero
    // read data stays put between reads
    // a read of control or mask has no side effect
    // summary reads do not clear anything
    // the host reads status to find the cause
    // read mux, registered data
    always @(posedge CLK) begin
        if (RST)
            RDATA <= 8'h00;
        else if (RD) begin
            if (ADDR >= `LIULB_ADDR_SUMMARY_LO)
                RDATA <= {{(8-NCH){1'b0}}, ch_irq};
            else
                case (ADDR)
                    `LIULB_ADDR_LOOP_CTRL: RDATA <= ctrl_q[CH_SEL];
                    `LIULB_ADDR_STATUS:    RDATA <= st_v[CH_SEL];
                    `LIULB_ADDR_IMASK:     RDATA <= mask_q[CH_SEL];
                    `LIULB_ADDR_RINFO1:    RDATA <= r1_v[CH_SEL];
                    `LIULB_ADDR_RINFO2:    RDATA <= r2_v[CH_SEL];
                    default:               RDATA <= 8'h00;
                endcase
        end
    end
    // low for any pending unmasked source
    // high when every channel is quiet
    // combinational from the registered flags
    // the pin is one summary across all channels
    // active-low interrupt output
    assign INT_N = ~(|ch_irq);
endmodule // liulb_bank
`default_nettype wire

// ### dv/liulb_bank_sva.sv
// assertions on the loopback/status bank host port and control outputs
// assumes host strobes at least two cycles apart, as the host model issues them
`default_nettype none
module liulb_bank_sva #(
    parameter NCH = 4
) (
    input wire logic             CLK,
    input wire logic             RST,
    input wire logic [1:0]       CH_SEL,
    input wire logic [4:0]       ADDR,
    input wire logic [7:0]       WDATA,
    input wire logic             WR,
    input wire logic             RD,
    input wire logic [7:0]       RDATA,
    input wire logic [NCH-1:0]   LOCAL_LOOP,
    input wire logic [NCH-1:0]   REMOTE_LOOP,
    input wire logic [NCH-1:0]   ANALOG_LOOP,
    input wire logic [3*NCH-1:0] ERR_CNT_SEL,
    input wire logic             INT_N
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // mask write followed by a read of the same place
    sequence s_mask_wr; WR && ADDR == 5'h07; endsequence
    sequence s_mask_rd; RD && ADDR == 5'h07 && CH_SEL == $past(CH_SEL, 2); endsequence
    a_mask_readback: assert property (
        s_mask_wr ##2 s_mask_rd |=> RDATA == $past(WDATA, 3)) else $error("mask readback");
    a_local_lag: assert property (
        WR && ADDR == 5'h05 && CH_SEL == 2'h0 |-> ##3 LOCAL_LOOP[0] == $past(WDATA[7], 3))
        else $error("local loop output");
    a_remote_manual: assert property (
        WR && ADDR == 5'h05 && WDATA[6] |-> ##3 REMOTE_LOOP[$past(CH_SEL, 3)])
        else $error("remote loop output");
    a_analog_lag: assert property (
        WR && ADDR == 5'h05 |-> ##3 ANALOG_LOOP[$past(CH_SEL, 3)] == $past(WDATA[4], 3))
        else $error("analog loop output");
    a_errsel_lag: assert property (
        WR && ADDR == 5'h05 |-> ##3 ERR_CNT_SEL[3*$past(CH_SEL, 3) +: 3] == $past(WDATA[2:0], 3))
        else $error("error count select");
    a_summary_idle: assert property (
        RD && ADDR >= 5'h16 && INT_N |=> RDATA == 8'h00) else $error("summary not clear");
    a_summary_busy: assert property (
        RD && ADDR >= 5'h16 && !INT_N |=> RDATA[3:0] != 4'h0 && RDATA[7:4] == 4'h0)
        else $error("summary empty");
    a_rdata_hold: assert property (!RD |=> $stable(RDATA)) else $error("read data moved");
    a_reset_clean: assert property (
        @(posedge CLK) disable iff (1'b0) RST |=> INT_N && LOCAL_LOOP == '0 && REMOTE_LOOP == '0)
        else $error("outputs active after reset");
endmodule // liulb_bank_sva
bind liulb_bank liulb_bank_sva #(.NCH(NCH)) u_sva (.CLK(CLK), .RST(RST), .CH_SEL(CH_SEL),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .LOCAL_LOOP(LOCAL_LOOP),
    .REMOTE_LOOP(REMOTE_LOOP), .ANALOG_LOOP(ANALOG_LOOP), .ERR_CNT_SEL(ERR_CNT_SEL),
    .INT_N(INT_N));
`default_nettype wire

// ### dv/liulb_host.sv
// host processor model: register writes, reads and the mask/read/write-back clear
// assumes one-cycle strobes taken at the rising edge and read data a cycle later
`default_nettype none
module liulb_host (
    input  wire logic       CLK,
    input  wire logic [7:0] RDATA,
    output var  logic [1:0] CH_SEL,
    output var  logic [4:0] ADDR,
    output var  logic [7:0] WDATA,
    output var  logic       WR,
    output var  logic       RD
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {CH_SEL, ADDR, WDATA, WR, RD} = '0;
    end
    // one write strobe; data line scrambled once released
    task automatic wr(input logic [1:0] c, input logic [4:0] a, input logic [7:0] d);
        @(posedge CLK) #1;
        {CH_SEL, ADDR, WDATA, WR} = {c, a, d, 1'b1};
        @(posedge CLK) #1;
        WR = 1'b0;
        WDATA = ~WDATA;
    endtask
    // one read strobe; data taken a cycle later
    task automatic rd(input logic [1:0] c, input logic [4:0] a, output logic [7:0] q);
        @(posedge CLK) #1;
        {CH_SEL, ADDR, RD} = {c, a, 1'b1};
        @(posedge CLK) #1;
        RD = 1'b0;
        q = RDATA;
    endtask
    // update mask, read, write back the masked result
    task automatic clr(input logic [1:0] c, input logic [4:0] a, input logic [7:0] m,
                       output logic [7:0] q);
        wr(c, a, m);
        rd(c, a, q);
        wr(c, a, q & m);
    endtask
endmodule // liulb_host
`default_nettype wire

// ### dv/liulb_tb.sv
// self-checking bench for the four-channel loopback/status bank
// assumes the host model drives the register port and a shortened code time
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int CYC = 20;
    logic        CLK, RST, WR, RD, INT_N;
    logic [1:0]  CH_SEL, c;
    logic [4:0]  ADDR;
    logic [7:0]  WDATA, RDATA, q, d;
    logic [31:0] STATUS_COND, RINFO1_COND, RINFO2_COND;
    logic [3:0]  LOOP_UP_SEEN, LOOP_DN_SEEN, LOCAL_LOOP, REMOTE_LOOP, ANALOG_LOOP, RX_JA_BYPASS;
    logic [11:0] ERR_CNT_SEL;
    logic [9:0]  rows [0:7] = '{10'h080, 10'h141, 10'h212, 10'h30b,
                                10'h014, 10'h18d, 10'h25e, 10'h327};
    int          bad_count, num_checks, cyc;
    liulb_host host (.CLK(CLK), .RDATA(RDATA), .CH_SEL(CH_SEL), .ADDR(ADDR), .WDATA(WDATA),
                     .WR(WR), .RD(RD));
    liulb_bank #(.NCH(4), .CODE_CYCLES(CYC)) uut (.CLK(CLK), .RST(RST), .CH_SEL(CH_SEL),
        .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .STATUS_COND(STATUS_COND), .RINFO1_COND(RINFO1_COND), .RINFO2_COND(RINFO2_COND),
        .LOOP_UP_SEEN(LOOP_UP_SEEN), .LOOP_DN_SEEN(LOOP_DN_SEEN), .LOCAL_LOOP(LOCAL_LOOP),
        .REMOTE_LOOP(REMOTE_LOOP), .ANALOG_LOOP(ANALOG_LOOP), .RX_JA_BYPASS(RX_JA_BYPASS),
        .ERR_CNT_SEL(ERR_CNT_SEL), .INT_N(INT_N));
    // compare and count
    task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge CLK) #1;
    endtask
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    // hang guard
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            end_sim();
        end
    end
    initial begin
        {STATUS_COND, RINFO1_COND, RINFO2_COND, LOOP_UP_SEEN, LOOP_DN_SEEN} = '0;
        RST = 1'b1;
        repeat (10) @(posedge CLK);
        #1 RST = 1'b0;
        chk("int idle", INT_N, 1'b1);
        host.rd(0, 5'h07, q);
        chk("mask reset", q, 8'h00);
        host.wr(1, 5'h07, 8'h5a);
        host.rd(1, 5'h07, q);
        chk("mask readback", q, 8'h5a);
        // control register rows: readback and loop outputs
        for (int i = 0; i < 8; i++) begin
            {c, d} = rows[i];
            host.wr(c, 5'h05, d);
            host.rd(c, 5'h05, q);
            chk("ctrl", q, d);
            chk("loop", {LOCAL_LOOP[c], REMOTE_LOOP[c], ANALOG_LOOP[c], RX_JA_BYPASS[c],
                ERR_CNT_SEL[3*c +: 3]}, {d[7:6], d[4:0]});
        end
        // latched event on channel 0
        host.wr(0, 5'h07, 8'h80);
        STATUS_COND[7] = 1'b1;
        waitc(1);
        STATUS_COND[7] = 1'b0;
        waitc(3);
        chk("event int", INT_N, 1'b0);
        host.rd(2, 5'h16, q);
        chk("summary", q, 8'h01);
        host.clr(0, 5'h06, 8'h80, q);
        chk("event bit", q, 8'h80);
        chk("event int off", INT_N, 1'b1);
        host.clr(0, 5'h06, 8'h80, q);
        chk("event cleared", q, 8'h00);
        RINFO1_COND[7] = 1'b1;
        waitc(1);
        RINFO1_COND[7] = 1'b0;
        host.clr(0, 5'h08, 8'h80, q);
        chk("info latch", q, 8'h80);
        host.clr(0, 5'h08, 8'h80, q);
        chk("info cleared", q, 8'h00);
        // persistent carrier loss on channel 2
        host.wr(2, 5'h07, 8'h08);
        STATUS_COND[19] = 1'b1;
        waitc(3);
        chk("alarm on int", INT_N, 1'b0);
        host.clr(2, 5'h06, 8'h08, q);
        chk("alarm int off", INT_N, 1'b1);
        host.clr(2, 5'h06, 8'h08, q);
        chk("alarm held", q, 8'h08);
        STATUS_COND[19] = 1'b0;
        waitc(3);
        chk("alarm off int", INT_N, 1'b0);
        host.clr(2, 5'h06, 8'h08, q);
        STATUS_COND[8] = 1'b1;
        waitc(3);
        chk("masked", INT_N, 1'b1);
        // automatic remote loop on channel 3
        host.wr(3, 5'h05, 8'h20);
        LOOP_UP_SEEN[3] = 1'b1;
        waitc(CYC / 2);
        chk("auto early", REMOTE_LOOP[3], 1'b0);
        waitc(CYC + 5);
        chk("auto in", REMOTE_LOOP[3], 1'b1);
        host.clr(3, 5'h09, 8'h02, q);
        chk("auto flag", q, 8'h02);
        {LOOP_UP_SEEN[3], LOOP_DN_SEEN[3]} = 2'b01;
        waitc(2 * CYC);
        chk("auto out", REMOTE_LOOP[3], 1'b0);
        {LOOP_UP_SEEN[3], LOOP_DN_SEEN[3]} = 2'b10;
        waitc(2 * CYC);
        chk("auto again", REMOTE_LOOP[3], 1'b1);
        host.wr(3, 5'h05, 8'h00);
        host.wr(3, 5'h05, 8'h20);
        waitc(5);
        chk("auto reset", REMOTE_LOOP[3], 1'b0);
        end_sim();
    end
endmodule // tb
`default_nettype wire
